// ### core/slr_pkg.sv
// Package for the switch lock, label and route configuration register bank.
package slr_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [23:0] SLR_OFF_LOCK = 24'h000068;
  localparam logic [23:0] SLR_OFF_LABEL = 24'h00006C;
  localparam logic [23:0] SLR_OFF_SELECT = 24'h000070;
  localparam logic [23:0] SLR_OFF_EGRESS = 24'h000074;
  localparam logic [23:0] SLR_OFF_PORT_INFO = 24'h000014;
  localparam logic [23:0] SLR_OFF_SRC_OPS = 24'h000018;
  localparam logic [23:0] SLR_OFF_TABLE_CAP = 24'h000078;
  localparam logic [23:0] SLR_OFF_DEF_ROUTE = 24'h00007C;

  // ---------------------------------------------------------------------------
  // Reset values, field positions and fixed values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] SLR_LOCK_FREE = 16'hFFFF;
  localparam logic [31:0] SLR_LABEL_RST = 32'h00000000;
  localparam logic [7:0] SLR_SEL_RST = 8'h00;
  localparam logic [7:0] SLR_PORT_TOTAL = 8'h08;
  localparam logic [7:0] SLR_UNMAPPED = 8'hFF;
  localparam logic [7:0] SLR_DEF_ROUTE_RST = 8'hFF;
  localparam logic [15:0] SLR_LUT_CAPACITY = 16'h01FF;
  localparam int SLR_PORT_WR_BIT = 2;
  localparam int SLR_NUM_PORTS = 8;
  localparam int SLR_LUT_DEPTH = 512;
  localparam int SLR_IDX_W = 9;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  // One maintenance request from the host side.
  typedef struct packed {
    logic valid;
    logic write;
    logic [23:0] offset;
    logic [31:0] wdata;
  } slr_req_t;

  // One completed answer.
  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } slr_rsp_t;

  // One routing lookup from the datapath.
  typedef struct packed {
    logic valid;
    logic [2:0] port;
    logic [15:0] dest_id;
  } slr_lkp_t;

  // One routing decision back to the datapath.
  typedef struct packed {
    logic valid;
    logic discard;
    logic [7:0] egress;
  } slr_dec_t;

  // Entry holds an egress port number at or above the port total, so it is unmapped.
  function automatic logic slr_is_unmapped(input logic [7:0] p);
    return p >= SLR_PORT_TOTAL;
  endfunction

  // Destination ID is inside the advertised lookup capacity.
  function automatic logic slr_id_valid(input logic [15:0] id);
    return id <= SLR_LUT_CAPACITY;
  endfunction

endpackage

// ### core/slr_lock.sv
// Write-once host ownership lock field.
`timescale 1ns/1ps
`default_nettype none
module slr_lock (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [15:0] wr_id,
  output logic [15:0] owner_id
);
  import slr_pkg::*;

  // ---------------------------------------------------------------------------
  // Lock state
  // ---------------------------------------------------------------------------
  logic [15:0] owner_r; // Stored owner, all ones while free.
  logic [15:0] owner_nxt; // Next owner.

  // Next owner: take a real ID while free, release on a matching write.
  always_comb
  begin
    owner_nxt = owner_r;
    if (wr_en)
    begin
      if (owner_r == SLR_LOCK_FREE)
      begin
        // All ones written while free keeps it free anyway.
        if (wr_id != SLR_LOCK_FREE) owner_nxt = wr_id;
      end
      else if (wr_id == owner_r)
      begin
        owner_nxt = SLR_LOCK_FREE;
      end
      // Any other value while held is dropped.
      else owner_nxt = owner_r;
    end
  end

  // Register the owner; reset leaves it unowned.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) owner_r <= SLR_LOCK_FREE;
    else owner_r <= owner_nxt;
  end

  assign owner_id = owner_r;
endmodule // slr_lock
`default_nettype wire

// ### core/slr_lut.sv
// Routing lookup tables, one copy per port.
`timescale 1ns/1ps
`default_nettype none
module slr_lut (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [8:0] cfg_idx,
  input wire logic [7:0] wr_port,
  output logic [7:0] cfg_rd_port,
  input wire slr_pkg::slr_lkp_t lkp,
  input wire logic [7:0] def_port,
  output slr_pkg::slr_dec_t dec
);
  import slr_pkg::*;

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  // Entries have no reset, as the egress field is undefined after reset.
  logic [7:0] routing_table [SLR_NUM_PORTS][SLR_LUT_DEPTH];
  slr_dec_t dec_r; // Registered decision.
  slr_dec_t dec_nxt; // Next decision.
  logic [7:0] hit; // Raw table entry for the lookup.

  // A configuration write lands in every port's copy in the same cycle.
  always_ff @(posedge core_clk)
  begin
    for (int p = 0; p < SLR_NUM_PORTS; p++)
    begin
      if (wr_en) routing_table[p][cfg_idx] <= wr_port;
    end
  end

  // Configuration reads only look at port 0's copy.
  assign cfg_rd_port = routing_table[0][cfg_idx];

  // Decide the egress for one lookup from the datapath.
  always_comb
  begin
    hit = routing_table[lkp.port][lkp.dest_id[SLR_IDX_W-1:0]];
    dec_nxt.valid = lkp.valid;
    dec_nxt.discard = 1'b0;
    dec_nxt.egress = hit;
    // IDs past the capacity behave like unmapped entries.
    if (!slr_id_valid(lkp.dest_id) || slr_is_unmapped(hit))
    begin
      dec_nxt.egress = def_port;
      dec_nxt.discard = slr_is_unmapped(def_port);
    end
  end

  // Register the decision so the output comes from flops.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) dec_r <= '0;
    else dec_r <= dec_nxt;
  end

  assign dec = dec_r;
endmodule // slr_lut
`default_nettype wire

// ### core/slr_regs.sv
// Switch ownership lock, component label and routing configuration registers.
// Operation
// - Lock ID resets to all ones, unowned.
// - First non-all-ones write while free takes lock.
// - Held lock ignores writes of other values.
// - Matching write releases lock to all ones.
// - Writing all ones never acquires the lock.
// - Lock never blocks any other access.
// - Writable 32-bit component label, reset zero.
// - Port-write capability bit reads fixed one.
// - Select low byte is ID low byte, reset zero.
// - Select second byte is ID high byte.
// - Egress write updates every port's table.
// - Egress read returns port 0 entry.
// - Egress field names the output port.
// - Unmapped hit uses the default route port.
// - Reported port total is eight.
// - Unmapped default discards; default resets 0xFF.
// - IDs up to 0x01FF index the tables.
`timescale 1ns/1ps
`default_nettype none
module slr_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire slr_pkg::slr_req_t req,
  output slr_pkg::slr_rsp_t rsp,
  input wire logic [7:0] rx_port_num,
  input wire slr_pkg::slr_lkp_t lkp,
  output slr_pkg::slr_dec_t dec,
  output logic [31:0] component_label_value,
  output logic [15:0] host_ownership_id
);
  import slr_pkg::*;

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  logic wr_lock; // Write to the lock register.
  logic wr_label; // Write to the label register.
  logic wr_select; // Write to the select register.
  logic wr_egress; // Write to the egress register.
  logic wr_def; // Write to the default route register.

  // Decode never consults the lock, so every access is served regardless.
  assign wr_lock = req.valid && req.write && (req.offset == SLR_OFF_LOCK);
  assign wr_label = req.valid && req.write && (req.offset == SLR_OFF_LABEL);
  assign wr_select = req.valid && req.write && (req.offset == SLR_OFF_SELECT);
  assign wr_egress = req.valid && req.write && (req.offset == SLR_OFF_EGRESS);
  assign wr_def = req.valid && req.write && (req.offset == SLR_OFF_DEF_ROUTE);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [31:0] label_r; // Component label.
  logic [31:0] label_nxt;
  logic [7:0] sel_hi_r; // Destination ID high byte.
  logic [7:0] sel_hi_nxt;
  logic [7:0] sel_lo_r; // Destination ID low byte.
  logic [7:0] sel_lo_nxt;
  logic [7:0] def_r; // Default route port.
  logic [7:0] def_nxt;
  slr_rsp_t rsp_r; // Registered answer.
  slr_rsp_t rsp_nxt;
  logic [7:0] cfg_rd_port; // Port 0 table entry at the selected ID.
  logic [15:0] route_select_id; // Full selected destination ID.

  assign route_select_id = {sel_hi_r, sel_lo_r};

  // Next values of the writable fields; only the documented bits are kept.
  always_comb
  begin
    label_nxt = label_r;
    sel_hi_nxt = sel_hi_r;
    sel_lo_nxt = sel_lo_r;
    def_nxt = def_r;
    if (wr_label) label_nxt = req.wdata;
    if (wr_select)
    begin
      sel_hi_nxt = req.wdata[15:8];
      sel_lo_nxt = req.wdata[7:0];
    end
    if (wr_def) def_nxt = req.wdata[7:0];
  end

  // Register the writable fields.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      label_r <= SLR_LABEL_RST;
      sel_hi_r <= SLR_SEL_RST;
      sel_lo_r <= SLR_SEL_RST;
      def_r <= SLR_DEF_ROUTE_RST;
    end
    else
    begin
      label_r <= label_nxt;
      sel_hi_r <= sel_hi_nxt;
      sel_lo_r <= sel_lo_nxt;
      def_r <= def_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Lock and routing tables
  // ---------------------------------------------------------------------------
  // The lock field keeps its own write-once state.
  slr_lock i_slr_lock (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(wr_lock),
    .wr_id(req.wdata[15:0]),
    .owner_id(host_ownership_id)
  );

  // Out-of-range select IDs are not written, so they cannot alias entries.
  slr_lut i_slr_lut (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(wr_egress && slr_id_valid(route_select_id)),
    .cfg_idx(route_select_id[SLR_IDX_W-1:0]),
    .wr_port(req.wdata[7:0]),
    .cfg_rd_port(cfg_rd_port),
    .lkp(lkp),
    .def_port(def_r),
    .dec(dec)
  );

  // ---------------------------------------------------------------------------
  // Read answer
  // ---------------------------------------------------------------------------
  // Every request gets an answer next cycle; unmapped offsets read zero.
  always_comb
  begin
    rsp_nxt.valid = req.valid;
    rsp_nxt.rdata = '0;
    if (req.valid && !req.write)
    begin
      unique case (req.offset)
        SLR_OFF_LOCK: rsp_nxt.rdata = {16'h0000, host_ownership_id};
        SLR_OFF_LABEL: rsp_nxt.rdata = label_r;
        SLR_OFF_SELECT: rsp_nxt.rdata = {16'h0000, route_select_id};
        SLR_OFF_EGRESS:
        begin
          // Out-of-range IDs report unmapped.
          if (slr_id_valid(route_select_id)) rsp_nxt.rdata = {24'h000000, cfg_rd_port};
          else rsp_nxt.rdata = {24'h000000, SLR_UNMAPPED};
        end
        SLR_OFF_PORT_INFO: rsp_nxt.rdata = {16'h0000, SLR_PORT_TOTAL, rx_port_num};
        SLR_OFF_SRC_OPS: rsp_nxt.rdata = 32'h1 << SLR_PORT_WR_BIT;
        SLR_OFF_TABLE_CAP: rsp_nxt.rdata = {16'h0000, SLR_LUT_CAPACITY};
        SLR_OFF_DEF_ROUTE: rsp_nxt.rdata = {24'h000000, def_r};
        default: rsp_nxt.rdata = '0;
      endcase
    end
  end

  // Register the answer.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) rsp_r <= '0;
    else rsp_r <= rsp_nxt;
  end

  assign rsp = rsp_r;
  assign component_label_value = label_r;
endmodule // slr_regs
`default_nettype wire

// ### sim/slr_regs_checker.sv
// Assertion checker for the lock, label and route register bank.
`timescale 1ns/1ps
`default_nettype none
module slr_regs_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire slr_pkg::slr_req_t req,
  input wire slr_pkg::slr_rsp_t rsp,
  input wire logic [7:0] rx_port_num,
  input wire slr_pkg::slr_lkp_t lkp,
  input wire slr_pkg::slr_dec_t dec,
  input wire logic [31:0] component_label_value,
  input wire logic [15:0] host_ownership_id
);
  import slr_pkg::*;
  // ----------------------------------------------------------------
  // Helper decode
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic wr_lock; // Write request aimed at the lock.
  logic held; // Lock currently owned.
  logic [15:0] wid; // Low half of the write data.
  assign wr_lock = req.valid && req.write && (req.offset == SLR_OFF_LOCK);
  assign held = host_ownership_id != SLR_LOCK_FREE;
  assign wid = req.wdata[15:0];
  property p_answer;
    req.valid |=> rsp.valid;
  endproperty
  a_answer: assert property (p_answer) else $error("request got no answer");
  property p_take;
    wr_lock && !held && (wid != SLR_LOCK_FREE) |=> host_ownership_id == $past(wid);
  endproperty
  a_take: assert property (p_take) else $error("free lock not taken");
  property p_keep;
    wr_lock && held && (wid != host_ownership_id) |=> $stable(host_ownership_id);
  endproperty
  a_keep: assert property (p_keep) else $error("held lock changed");
  property p_release;
    wr_lock && held && (wid == host_ownership_id) |=> !held;
  endproperty
  a_release: assert property (p_release) else $error("lock not released");
  property p_never;
    wr_lock && !held && (wid == SLR_LOCK_FREE) |=> !held;
  endproperty
  a_never: assert property (p_never) else $error("all ones took the lock");
  property p_rd_lock;
    req.valid && !req.write && (req.offset == SLR_OFF_LOCK)
      |=> rsp.rdata == {16'h0000, $past(host_ownership_id)};
  endproperty
  a_rd_lock: assert property (p_rd_lock) else $error("lock read wrong");
  property p_label;
    req.valid && req.write && (req.offset == SLR_OFF_LABEL)
      |=> component_label_value == $past(req.wdata);
  endproperty
  a_label: assert property (p_label) else $error("label not written");
  property p_pw;
    req.valid && !req.write && (req.offset == SLR_OFF_SRC_OPS) |=> rsp.rdata[SLR_PORT_WR_BIT];
  endproperty
  a_pw: assert property (p_pw) else $error("port-write bit clear");
  property p_total;
    req.valid && !req.write && (req.offset == SLR_OFF_PORT_INFO)
      |=> rsp.rdata == {16'h0000, SLR_PORT_TOTAL, $past(rx_port_num)};
  endproperty
  a_total: assert property (p_total) else $error("port info wrong");
  // A routed decision never names an unmapped port.
  property p_dec;
    lkp.valid |=> dec.valid && (dec.discard || (dec.egress < SLR_PORT_TOTAL));
  endproperty
  a_dec: assert property (p_dec) else $error("bad lookup decision");
  c_take: cover property (wr_lock && !held && (wid != SLR_LOCK_FREE));
  c_release: cover property (wr_lock && held && (wid == host_ownership_id));
  c_discard: cover property (dec.valid && dec.discard);
endmodule // slr_regs_checker
bind slr_regs slr_regs_checker i_slr_regs_checker (.core_clk(core_clk), .rst(rst),
  .req(req), .rsp(rsp), .rx_port_num(rx_port_num), .lkp(lkp), .dec(dec),
  .component_label_value(component_label_value), .host_ownership_id(host_ownership_id));
`default_nettype wire

// ### sim/slr_host_model.sv
// Host model issuing maintenance reads and writes to the register bank.
`timescale 1ns/1ps
`default_nettype none
module slr_host_model (
  input wire logic core_clk,
  output var slr_pkg::slr_req_t req,
  input wire slr_pkg::slr_rsp_t rsp
);
  import slr_pkg::*;
  initial req = '0;
  // One request held over its sampling edge; released fields show
  // inverted values so a stale bus is never mistaken for live data.
  task automatic xfer(input logic w, input logic [23:0] o, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    ok = 1'b0;
    q = '0;
    @(negedge core_clk);
    req <= '{valid: 1'b1, write: w, offset: o, wdata: d};
    @(negedge core_clk);
    req <= '{valid: 1'b0, write: ~w, offset: ~o, wdata: ~d};
    for (int i = 0; i < 3 && !ok; i++)
    begin
      if (rsp.valid === 1'b1)
      begin
        ok = 1'b1;
        q = rsp.rdata;
      end
      else
        @(negedge core_clk);
    end
  endtask
  // Claim the lock, then read it back before trusting the claim.
  task automatic claim(input logic [15:0] id, output logic owned);
    logic [31:0] q;
    logic ok;
    xfer(1'b1, SLR_OFF_LOCK, {16'h0000, id}, q, ok);
    xfer(1'b0, SLR_OFF_LOCK, 32'h00000000, q, ok);
    owned = ok && (q[15:0] === id);
  endtask
endmodule // slr_host_model
`default_nettype wire

// ### sim/slr_regs_test.sv
// Self-checking bench for the lock, label and route register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module slr_regs_test;
  import slr_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] rx_port_num = 8'h03;
  slr_req_t req;
  slr_rsp_t rsp;
  slr_lkp_t lkp = '0;
  slr_dec_t dec;
  logic [31:0] component_label_value;
  logic [15:0] host_ownership_id;
  int num_errors = 0;
  int checks_done = 0;
  always #5 core_clk = ~core_clk;
  slr_regs i_slr_regs (.core_clk(core_clk), .rst(rst), .req(req), .rsp(rsp),
    .rx_port_num(rx_port_num), .lkp(lkp), .dec(dec),
    .component_label_value(component_label_value), .host_ownership_id(host_ownership_id));
  slr_host_model i_slr_host_model (.core_clk(core_clk), .req(req), .rsp(rsp));
  // A missing answer counts as a mismatch.
  task automatic acc(input logic w, input logic [23:0] o, input logic [31:0] d,
                     output logic [31:0] q);
    logic ok;
    i_slr_host_model.xfer(w, o, d, q, ok);
    `CHK(ok, 1'b1)
    // A missing answer ends the run at once rather than cascading.
    if (!ok) stop_test();
  endtask
  task automatic wr(input logic [23:0] o, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, o, d, q);
  endtask
  task automatic rd_chk(input logic [23:0] o, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, o, 32'h00000000, q);
    `CHK(q, e)
  endtask
  // One lookup; the decision stands in the following cycle.
  task automatic lk(input logic [2:0] p, input logic [15:0] id, input logic [7:0] e,
                    input logic x);
    @(negedge core_clk);
    lkp <= '{valid: 1'b1, port: p, dest_id: id};
    @(negedge core_clk);
    lkp <= '0;
    `CHK({dec.valid, dec.discard, dec.egress}, {1'b1, x, e})
  endtask
  task automatic t_reset();
    rd_chk(SLR_OFF_LOCK, 32'h0000FFFF);
    rd_chk(SLR_OFF_LABEL, 32'h00000000);
    rd_chk(SLR_OFF_SELECT, 32'h00000000);
    wr(SLR_OFF_SRC_OPS, 32'hFFFFFFFF);
    rd_chk(SLR_OFF_SRC_OPS, 32'h00000004);
    rd_chk(SLR_OFF_PORT_INFO, 32'h00000803);
    // The receiving port number must follow its input, not stick.
    rx_port_num = 8'h05;
    rd_chk(SLR_OFF_PORT_INFO, 32'h00000805);
    rd_chk(SLR_OFF_TABLE_CAP, 32'h000001FF);
    rd_chk(SLR_OFF_DEF_ROUTE, 32'h000000FF);
    rd_chk(24'h000060, 32'h00000000);
    $display("test reset done");
  endtask
  task automatic t_lock();
    logic own;
    wr(SLR_OFF_LOCK, 32'h0000FFFF);
    rd_chk(SLR_OFF_LOCK, 32'h0000FFFF);
    i_slr_host_model.claim(16'h1234, own);
    `CHK(own, 1'b1)
    wr(SLR_OFF_LOCK, 32'h00005678);
    `CHK(host_ownership_id, 16'h1234)
    wr(SLR_OFF_LABEL, 32'hA5A55A5A);
    rd_chk(SLR_OFF_LABEL, 32'hA5A55A5A);
    `CHK(component_label_value, 32'hA5A55A5A)
    wr(SLR_OFF_LOCK, 32'h00001234);
    rd_chk(SLR_OFF_LOCK, 32'h0000FFFF);
    wr(SLR_OFF_LOCK, 32'hABCD0042);
    rd_chk(SLR_OFF_LOCK, 32'h00000042);
    $display("test lock done");
  endtask
  task automatic t_route();
    int p;
    wr(SLR_OFF_SELECT, 32'hFFFF0105);
    rd_chk(SLR_OFF_SELECT, 32'h00000105);
    wr(SLR_OFF_EGRESS, 32'h00000003);
    rd_chk(SLR_OFF_EGRESS, 32'h00000003);
    for (p = 0; p < SLR_NUM_PORTS; p++)
      lk(p[2:0], 16'h0105, 8'h03, 1'b0);
    wr(SLR_OFF_EGRESS, 32'h00000008);
    lk(3'd0, 16'h0105, 8'hFF, 1'b1);
    wr(SLR_OFF_DEF_ROUTE, 32'h00000006);
    lk(3'd7, 16'h0105, 8'h06, 1'b0);
    wr(SLR_OFF_EGRESS, 32'h00000007);
    lk(3'd4, 16'h0105, 8'h07, 1'b0);
    wr(SLR_OFF_SELECT, 32'h00000200);
    wr(SLR_OFF_EGRESS, 32'h00000001);
    rd_chk(SLR_OFF_EGRESS, 32'h000000FF);
    lk(3'd1, 16'h0200, 8'h06, 1'b0);
    wr(SLR_OFF_SELECT, 32'h000001FF);
    wr(SLR_OFF_EGRESS, 32'h000000FF);
    lk(3'd2, 16'h01FF, 8'h06, 1'b0);
    $display("test route done");
  endtask
  // A reset in mid-run must drop a held lock and clear the label.
  task automatic t_rerst();
    @(negedge core_clk);
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    `CHK(host_ownership_id, 16'hFFFF)
    rd_chk(SLR_OFF_LOCK, 32'h0000FFFF);
    rd_chk(SLR_OFF_LABEL, 32'h00000000);
    $display("test mid reset done");
  endtask
  task automatic stop_test();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_lock();
    t_rerst();
    t_route();
    stop_test();
  end
endmodule // slr_regs_test
`default_nettype wire
